/* File: src/ptg_gen.sv */
/*
  Holds the test pattern generator: a nine-stage sequence XORed onto the serial data stream.
  Assumes the serial data line and the enable bit arrive from outside the clock domain and
  that bits are presented as one-cycle strobes from the config_register_a bit clock logic.
*/
`timescale 1ns/100ps
module ptg_gen #(
  parameter int DEPTH = ptg_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic prbs_gen_enable_bit,
  input wire logic serial_data_line,
  input wire logic bit_strobe,
  input wire logic tx_mode,
  input wire logic out_ready,
  output logic out_valid,
  output ptg_pkg::ptg_word_t out_word,
  output logic in_ready
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic en_s1_r;
  logic en_s2_r;
  logic dat_s1_r;
  logic dat_s2_r;
  logic en_d_r;
  // Enable bit synchroniser.
  // The delayed copy resets low like the idle pin, so reset gives no false rise.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      en_d_r <= 1'b0;
    end else begin
      en_s1_r <= prbs_gen_enable_bit;
      en_s2_r <= en_s1_r;
      en_d_r <= en_s2_r;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dat_s1_r <= 1'b0;
      dat_s2_r <= 1'b0;
    end else begin
      dat_s1_r <= serial_data_line;
      dat_s2_r <= dat_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequence register
  // ----------------------------------------------------------------
  logic [ptg_pkg::LFSR_LEN-1:0] lfsr_r;
  logic [ptg_pkg::LFSR_LEN-1:0] lfsr_nxt;
  wire en_rise = en_s2_r & ~en_d_r;
  wire take = bit_strobe & in_ready;
  wire fb = lfsr_r[ptg_pkg::TAP_HI] ^ lfsr_r[ptg_pkg::TAP_LO];
  wire step = en_s2_r & take;
  assign lfsr_nxt = en_rise ? ptg_pkg::LFSR_SEED :
                    step ? {lfsr_r[ptg_pkg::LFSR_LEN-2:0], fb} : lfsr_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lfsr_r <= ptg_pkg::LFSR_SEED;
    end else begin
      lfsr_r <= lfsr_nxt;
    end
  end

  wire mixed = dat_s2_r ^ (en_s2_r & lfsr_r[ptg_pkg::TAP_HI]);
  wire ptg_pkg::ptg_dir_t dir_sel = tx_mode ? ptg_pkg::PTG_TX : ptg_pkg::PTG_RX;
  ptg_pkg::ptg_word_t in_word;
  assign in_word = '{bit_val: mixed, dir: dir_sel};

  // ----------------------------------------------------------------
  // Two-entry buffer
  // ----------------------------------------------------------------
  // A stalled receiver also holds the sequence still once the buffer is full and strobes are refused, so no bit is misaligned.
  localparam int AW = $clog2(DEPTH);
  ptg_pkg::ptg_word_t mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] wp_inc = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
  wire [AW-1:0] rp_inc = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
  wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(take) - (AW+1)'(pop);
  wire [AW-1:0] rp_nxt = pop ? rp_inc : rp_r;
  wire [AW-1:0] wp_nxt = take ? wp_inc : wp_r;
  wire in_ready_nxt = cnt_nxt != (AW+1)'(DEPTH);
  wire out_valid_nxt = cnt_nxt != '0;
  // A word taken while the buffer is empty or its last word leaves bypasses storage, so latency stays one cycle.
  wire bypass = take && (wp_r == rp_nxt);
  wire ptg_pkg::ptg_word_t out_word_nxt = bypass ? in_word : mem_r[rp_nxt];

  // Pointers and fill count.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Handshake flags, straight from flip-flops.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      in_ready <= in_ready_nxt;
      out_valid <= out_valid_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      out_word <= '0;
    end else begin
      out_word <= out_word_nxt;
    end
  end
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_mem
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          mem_r[i] <= '0;
        end else if (take && wp_r == AW'(i)) begin
          mem_r[i] <= in_word;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  lock_free_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    lfsr_r != ptg_pkg::LFSR_ZERO)
    else $error("Sequence register reached all zero.");
  hold_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!en_s2_r && !en_rise) |=> $stable(lfsr_r))
    else $error("Sequence advanced while disabled.");
  shift_poly_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (step && !en_rise) |=> lfsr_r == {$past(lfsr_r[7:0]),
      $past(lfsr_r[8]) ^ $past(lfsr_r[4])})
    else $error("Sequence step does not follow the polynomial.");
  seed_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    en_rise |=> lfsr_r == ptg_pkg::LFSR_SEED)
    else $error("Seed not loaded on enable.");
  xor_path_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    in_word.bit_val == (dat_s2_r ^ (en_s2_r & lfsr_r[8])))
    else $error("Stream bit not mixed with sequence.");
  pass_thru_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !en_s2_r |-> in_word.bit_val == dat_s2_r)
    else $error("Stream altered while disabled.");
  buf_full_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cnt_r == (AW+1)'(DEPTH) |-> !in_ready)
    else $error("Buffer accepts while full.");
  buf_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (out_valid && !out_ready) |=> out_valid && $stable(out_word))
    else $error("Output word dropped under stall.");

  // ----------------------------------------------------------------
  // Buffer, handshake, direction tag and sequence checks
  // ----------------------------------------------------------------
  cnt_bound_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cnt_r <= (AW+1)'(DEPTH))
    else $error("Buffer count beyond depth.");
  refuse_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (bit_strobe && !in_ready && !en_rise) |=> $stable(lfsr_r))
    else $error("Refused strobe advanced the sequence.");
  ready_empty_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cnt_r == '0 |-> in_ready)
    else $error("Empty buffer refuses.");
  take_valid_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take |=> out_valid)
    else $error("Taken bit not offered.");
  drain_last_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (pop && !take && cnt_r == (AW+1)'(1)) |=> !out_valid)
    else $error("Valid stays after last word left.");
  fill_last_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && !pop && cnt_r == (AW+1)'(DEPTH-1)) |=> !in_ready)
    else $error("Ready stays after buffer filled.");
  rx_tag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && !tx_mode) |-> in_word.dir == ptg_pkg::PTG_RX)
    else $error("Receive bit tagged as transmit.");
  tx_tag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && tx_mode) |-> in_word.dir == ptg_pkg::PTG_TX)
    else $error("Transmit bit tagged as receive.");
  first_word_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && cnt_r == '0) |=> out_word == $past(in_word))
    else $error("First word not passed straight through.");
  seq_mix_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (en_s2_r && take) |-> in_word.bit_val == (dat_s2_r ^ lfsr_r[ptg_pkg::TAP_HI]))
    else $error("Enabled bit not mixed with sequence output.");
endmodule // ptg_gen

/* File: src/ptg_pkg.sv */
/*
  Constants and carrier types for the built-in pseudo-random test pattern generator.
  Assumes a single system clock domain and an active-low asynchronous chip reset.
*/
package ptg_pkg;
  // ----------------------------------------------------------------
  // Sequence generator constants
  // ----------------------------------------------------------------
  localparam int LFSR_LEN = 9;
  localparam int TAP_HI = 8;
  localparam int TAP_LO = 4;
  localparam logic [LFSR_LEN-1:0] LFSR_SEED = 9'h1ff;
  localparam logic [LFSR_LEN-1:0] LFSR_ZERO = 9'h000;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic {PTG_RX, PTG_TX} ptg_dir_t;

  typedef struct packed {
    logic bit_val;
    ptg_dir_t dir;
  } ptg_word_t;
endpackage

/* File: test/ptg_host.sv */
/* Host model that takes generated words, with a stall input.
   Assumes it shares the generator's clock. */
`timescale 1ns/100ps
module ptg_host (
  input wire logic clk_sys,
  input wire logic stall,
  input wire logic out_valid,
  input wire ptg_pkg::ptg_word_t out_word,
  output logic out_ready,
  output logic got,
  output ptg_pkg::ptg_word_t got_word
);
  // Every popped word passes on for the host to count.
  assign out_ready = !stall;
  always_ff @(posedge clk_sys) begin
    got <= out_valid && out_ready;
    got_word <= out_word;
  end
endmodule // ptg_host

/* File: test/ptg_gen_tb.sv */
/* Self-checking bench for the test pattern generator.
   Assumes ptg_pkg and ptg_gen are compiled first. */
`timescale 1ns/100ps
module ptg_gen_tb;
  logic clk_sys = 0, nrst = 0, en = 0, sdl = 0, strb = 0, txm = 0, stall = 0;
  logic out_valid, in_ready, out_ready, got;
  ptg_pkg::ptg_word_t out_word, got_word;
  ptg_pkg::ptg_word_t exp_q[$];
  logic [8:0] lfsr = 9'h1ff;
  int failures = 0, cmp_count = 0, cyc = 0;
  always #10 clk_sys = ~clk_sys;
  ptg_gen dut_u (.clk_sys(clk_sys), .nrst(nrst), .prbs_gen_enable_bit(en),
    .serial_data_line(sdl), .bit_strobe(strb), .tx_mode(txm), .out_ready(out_ready),
    .out_valid(out_valid), .out_word(out_word), .in_ready(in_ready));
  ptg_host host_u (.clk_sys(clk_sys), .stall(stall), .out_valid(out_valid),
    .out_word(out_word), .out_ready(out_ready), .got(got), .got_word(got_word));
  task automatic check(string what, logic [1:0] seen, logic [1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %b seen %b", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A refused strobe must not advance the sequence, so the model steps only on a take.
  task automatic send(logic tx);
    @(posedge clk_sys);
    strb <= 1;
    txm <= tx;
    @(posedge clk_sys);
    strb <= 0;
    if (in_ready === 1'b1) begin
      exp_q.push_back(ptg_pkg::ptg_word_t'({sdl ^ (en & lfsr[8]), tx}));
      if (en) lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};
    end
  endtask
  task automatic sc_off();
    sdl <= 1;
    repeat (4) @(posedge clk_sys);
    send(1);
    send(0);
  endtask
  task automatic sc_seq(logic d);
    en <= 0;
    sdl <= d;
    repeat (5) @(posedge clk_sys);
    en <= 1;
    repeat (3) @(posedge clk_sys);
    // host toggles the line after enabling
    sdl <= ~d;
    @(posedge clk_sys);
    sdl <= d;
    repeat (5) @(posedge clk_sys);
    lfsr = 9'h1ff;
    for (int i = 0; i < 20; i++) send(i[0]);
  endtask
  task automatic sc_stall();
    stall <= 1;
    repeat (3) send(1);
    check("in_ready", {1'b0, in_ready}, 2'b00);
    stall <= 0;
    repeat (6) @(posedge clk_sys);
    send(0);
    repeat (4) @(posedge clk_sys);
    check("left", 2'(exp_q.size()), 2'b00);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (got) check("word", got_word, exp_q.pop_front());
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1;
    sc_off();
    sc_seq(0);
    sc_seq(1);
    sc_stall();
    end_sim();
  end
endmodule // ptg_gen_tb
